// >>> hdl/link_health_pkg.sv
package link_health_pkg;

    localparam int unsigned ADDR_W          = 12;
    localparam int unsigned DATA_W          = 8;
    localparam int unsigned NUM_LANES       = 2;

    localparam logic [ADDR_W-1:0] LANE2_HEALTH_OFS = 12'h4B2;
    localparam logic [ADDR_W-1:0] LANE3_HEALTH_OFS = 12'h4B3;

    localparam logic [DATA_W-1:0] HEALTH_RESET     = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_RDATA   = 8'h00;
    localparam logic [7:0]        ERR_CNT_MAX      = 8'hFF;
    localparam logic [7:0]        ERR_CNT_RESET    = 8'h00;

    localparam int unsigned BIT_DISPARITY   = 7;
    localparam int unsigned BIT_INVALID     = 6;
    localparam int unsigned BIT_STRAY_CTRL  = 5;
    localparam int unsigned BIT_DESKEW      = 4;
    localparam int unsigned BIT_LANE_SYNC   = 3;
    localparam int unsigned BIT_CHECKSUM    = 2;
    localparam int unsigned BIT_FRAME_SYNC  = 1;
    localparam int unsigned BIT_CODE_GROUP  = 0;

    // Saturating increment keeps a noisy lane from wrapping to a low count.
    function automatic logic [7:0] sat_inc(input logic [7:0] cnt,
                                           input logic       evt);
        if (evt && (cnt != ERR_CNT_MAX)) begin
            return 8'(cnt + 8'h01);
        end
        return cnt;
    endfunction : sat_inc

endpackage : link_health_pkg

// >>> hdl/lane_status_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lane_status_if;
    logic       disparity_err;
    logic       invalid_code_err;
    logic       stray_ctrl_err;
    logic       deskew_done;
    logic       initial_lane_sync_ok;
    logic       config_checksum_ok;
    logic       frame_sync_ok;
    logic       code_group_sync_ok;
    logic [7:0] health;

    modport tracker (
        input  disparity_err,
        input  invalid_code_err,
        input  stray_ctrl_err,
        input  deskew_done,
        input  initial_lane_sync_ok,
        input  config_checksum_ok,
        input  frame_sync_ok,
        input  code_group_sync_ok,
        output health
    );

    modport bank (
        output disparity_err,
        output invalid_code_err,
        output stray_ctrl_err,
        output deskew_done,
        output initial_lane_sync_ok,
        output config_checksum_ok,
        output frame_sync_ok,
        output code_group_sync_ok,
        input  health
    );
endinterface : lane_status_if
`default_nettype wire

// >>> hdl/lane_health_tracker.sv
`timescale 1ns/1ps
`default_nettype none
module lane_health_tracker
    import link_health_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic [7:0] error_threshold,
    input  wire logic       clear_error_counts,
    lane_status_if.tracker  lane
);

    logic [7:0] disp_cnt_reg;
    logic [7:0] disp_cnt_next;
    logic [7:0] nit_cnt_reg;
    logic [7:0] nit_cnt_next;
    logic [7:0] stray_cnt_reg;
    logic [7:0] stray_cnt_next;
    logic [7:0] health_reg;
    logic [7:0] health_next;

    always_comb begin
        disp_cnt_next  = sat_inc(disp_cnt_reg, lane.disparity_err);     // R13
        nit_cnt_next   = sat_inc(nit_cnt_reg, lane.invalid_code_err);   // R13
        stray_cnt_next = sat_inc(stray_cnt_reg, lane.stray_ctrl_err);   // R13
        if (clear_error_counts) begin
            disp_cnt_next  = ERR_CNT_RESET;
            nit_cnt_next   = ERR_CNT_RESET;
            stray_cnt_next = ERR_CNT_RESET;
        end
        health_next = HEALTH_RESET;
        // Flags follow the counts one cycle late, so a read sees a settled
        // comparison rather than one racing a counter update.
        health_next[BIT_DISPARITY]  = disp_cnt_reg >= error_threshold; // R1 R4
        health_next[BIT_INVALID]    = nit_cnt_reg >= error_threshold; // R2 R4
        health_next[BIT_STRAY_CTRL] = stray_cnt_reg >= error_threshold; // R3
        // The sync bits are passed through unconditionally; when the
        // alignment sequence is skipped software must ignore bits 4 to 1.
        health_next[BIT_DESKEW]     = lane.deskew_done; // R5 R10
        health_next[BIT_LANE_SYNC]  = lane.initial_lane_sync_ok;        // R6
        health_next[BIT_CHECKSUM]   = lane.config_checksum_ok;          // R7
        health_next[BIT_FRAME_SYNC] = lane.frame_sync_ok;               // R8
        health_next[BIT_CODE_GROUP] = lane.code_group_sync_ok;          // R9
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            disp_cnt_reg  <= ERR_CNT_RESET;
            nit_cnt_reg   <= ERR_CNT_RESET;
            stray_cnt_reg <= ERR_CNT_RESET;
            health_reg    <= HEALTH_RESET;                              // R12
        end else begin
            disp_cnt_reg  <= disp_cnt_next;
            nit_cnt_reg   <= nit_cnt_next;
            stray_cnt_reg <= stray_cnt_next;
            health_reg    <= health_next;
        end
    end

    assign lane.health = health_reg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    AST_DISP_FLAG: assert property ( // R1
        1'b1 |=> lane.health[BIT_DISPARITY] ==
                 ($past(disp_cnt_reg) >= $past(error_threshold)))
        else $error("Disparity flag disagrees with count and threshold.");

    AST_NIT_FLAG: assert property ( // R2
        (nit_cnt_reg == error_threshold) |=> lane.health[BIT_INVALID])
        else $error("Invalid code flag clear with count at threshold.");

    AST_STRAY_FLAG: assert property ( // R3
        (stray_cnt_reg < error_threshold) |=> !lane.health[BIT_STRAY_CTRL])
        else $error("Stray control flag set with count below threshold.");

    AST_THRESHOLD_EDGE: assert property ( // R4
        (disp_cnt_reg == error_threshold) && !clear_error_counts
            |=> lane.health[BIT_DISPARITY])
        else $error("Count equal to threshold did not set flag.");

    AST_COUNT_STEP: assert property ( // R13
        lane.disparity_err && !clear_error_counts &&
        (disp_cnt_reg != ERR_CNT_MAX)
            |=> disp_cnt_reg == 8'($past(disp_cnt_reg) + 8'h01))
        else $error("Disparity counter failed to advance by one.");

    AST_COUNT_SATURATE: assert property ( // R13
        (disp_cnt_reg == ERR_CNT_MAX) && !clear_error_counts
            |=> disp_cnt_reg == ERR_CNT_MAX)
        else $error("Disparity counter wrapped past its maximum.");

    AST_SYNC_BITS: assert property ( // R5
        1'b1 |=> lane.health[4:0] == $past({lane.deskew_done,
                  lane.initial_lane_sync_ok, lane.config_checksum_ok,
                  lane.frame_sync_ok, lane.code_group_sync_ok}))
        else $error("Sync status bits do not follow lane state.");

    AST_CODE_GROUP: assert property ( // R9
        $fell(lane.code_group_sync_ok) |=> !lane.health[BIT_CODE_GROUP])
        else $error("Code group bit still set after sync loss.");

    COV_DISP_TRIP: cover property (
        !lane.health[BIT_DISPARITY] ##1 lane.health[BIT_DISPARITY]);
    COV_SATURATE: cover property (disp_cnt_reg == ERR_CNT_MAX);

endmodule : lane_health_tracker
`default_nettype wire

// >>> hdl/serial_lane_link_status.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1 - Bit 7: disparity count at/above threshold
// R2 - Bit 6: not-in-table count reaches threshold
// R3 - Bit 5: misplaced control-char count reaches threshold
// R4 - Flags compare greater-or-equal against threshold
// R5 - Bit 4: inter-lane deskew achieved
// R6 - Bit 3: initial lane sync achieved
// R7 - Bit 2: config checksum correct
// R8 - Bit 1: frame sync achieved
// R9 - Bit 0: code group sync, always valid
// R10 - Bits 4..1 meaningless when alignment skipped
// R11 - Lane 2 at 0x4B2, lane 3 at 0x4B3
// R12 - All bits reset zero, read-only
// R13 - Saturating per-lane counters per error type
module serial_lane_link_status
    import link_health_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 reset_n,
    input  wire logic [ADDR_W-1:0]    reg_addr,
    input  wire logic                 reg_rd_en,
    input  wire logic                 reg_wr_en,
    input  wire logic [DATA_W-1:0]    reg_wdata,
    output var  logic [DATA_W-1:0]    reg_rdata,
    output var  logic                 reg_rd_valid,
    input  wire logic [7:0]           error_threshold,
    input  wire logic                 clear_error_counts,
    input  wire logic                 skip_alignment_sequence,
    input  wire logic [NUM_LANES-1:0] disparity_err,
    input  wire logic [NUM_LANES-1:0] invalid_code_err,
    input  wire logic [NUM_LANES-1:0] stray_ctrl_err,
    input  wire logic [NUM_LANES-1:0] deskew_done,
    input  wire logic [NUM_LANES-1:0] initial_lane_sync_ok,
    input  wire logic [NUM_LANES-1:0] config_checksum_ok,
    input  wire logic [NUM_LANES-1:0] frame_sync_ok,
    input  wire logic [NUM_LANES-1:0] code_group_sync_ok
);

    logic [DATA_W-1:0] lane_health [NUM_LANES];
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic              rd_valid_reg;
    logic              rd_valid_next;
    logic              addr_hit;

    lane_status_if lane_bus [NUM_LANES] ();

    for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
        assign lane_bus[g].disparity_err        = disparity_err[g];
        assign lane_bus[g].invalid_code_err     = invalid_code_err[g];
        assign lane_bus[g].stray_ctrl_err       = stray_ctrl_err[g];
        assign lane_bus[g].deskew_done          = deskew_done[g];
        assign lane_bus[g].initial_lane_sync_ok = initial_lane_sync_ok[g];
        assign lane_bus[g].config_checksum_ok   = config_checksum_ok[g];
        assign lane_bus[g].frame_sync_ok        = frame_sync_ok[g];
        assign lane_bus[g].code_group_sync_ok   = code_group_sync_ok[g];
        assign lane_health[g]                   = lane_bus[g].health;

        lane_health_tracker u_tracker (
            .ref_clk            (ref_clk),
            .reset_n            (reset_n),
            .error_threshold    (error_threshold),
            .clear_error_counts (clear_error_counts),
            .lane               (lane_bus[g])
        );
    end

    // Read decode. Writes are accepted on the port but touch nothing, so a
    // stray write can never mask a real link fault.
    always_comb begin
        addr_hit      = 1'b1;
        rd_valid_next = reg_rd_en;
        rdata_next    = rdata_reg;
        if (reg_rd_en) begin
            unique case (reg_addr)
                LANE2_HEALTH_OFS: rdata_next = lane_health[0];          // R11
                LANE3_HEALTH_OFS: rdata_next = lane_health[1];          // R11
                default: begin
                    rdata_next = UNMAPPED_RDATA;
                    addr_hit   = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg    <= HEALTH_RESET;                               // R12
            rd_valid_reg <= 1'b0;
        end else begin
            rdata_reg    <= rdata_next;
            rd_valid_reg <= rd_valid_next;
        end
    end

    assign reg_rdata    = rdata_reg;
    assign reg_rd_valid = rd_valid_reg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    AST_RD_LANE2: assert property ( // R11
        reg_rd_en && (reg_addr == LANE2_HEALTH_OFS)
            |=> reg_rd_valid && (reg_rdata == $past(lane_health[0])))
        else $error("Lane 2 read returned wrong data.");

    AST_RD_LANE3: assert property ( // R11
        reg_rd_en && (reg_addr == LANE3_HEALTH_OFS)
            |=> reg_rd_valid && (reg_rdata == $past(lane_health[1])))
        else $error("Lane 3 read returned wrong data.");

    AST_RD_UNMAPPED: assert property (
        reg_rd_en && !addr_hit
            |=> reg_rd_valid && (reg_rdata == UNMAPPED_RDATA))
        else $error("Unmapped read did not return zero.");

    AST_RESET_ZERO: assert property ( // R12
        $rose(reset_n) |-> (reg_rdata == HEALTH_RESET) && !reg_rd_valid &&
                           (lane_health[0] == HEALTH_RESET) &&
                           (lane_health[1] == HEALTH_RESET))
        else $error("Status not zero straight after reset.");

    AST_WRITE_IGNORED: assert property ( // R12
        reg_wr_en && !reg_rd_en |=> !reg_rd_valid &&
                                    (reg_rdata == $past(reg_rdata)))
        else $error("Write disturbed the read path.");

    AST_SKIP_KEEPS_CGS: assert property ( // R10
        skip_alignment_sequence && code_group_sync_ok[0]
            |=> lane_health[0][BIT_CODE_GROUP])
        else $error("Code group bit lost while alignment skipped.");

    COV_READ_LANE2: cover property (
        reg_rd_en && (reg_addr == LANE2_HEALTH_OFS));
    COV_READ_ALL_OK: cover property (
        reg_rd_valid && (reg_rdata[4:0] == 5'h1F));
    COV_BACK_TO_BACK: cover property (reg_rd_en [*2]);

endmodule : serial_lane_link_status
`default_nettype wire

// >>> verification/lane_source_model.sv
`timescale 1ns/1ps
`default_nettype none
// Transmitter end of the lanes: raises error events and sync levels.
// Everything changes on the falling edge so the block samples settled values.
module lane_source_model (
    input  wire logic       ref_clk,
    output var  logic [1:0] disparity_err,
    output var  logic [1:0] invalid_code_err,
    output var  logic [1:0] stray_ctrl_err,
    output var  logic [1:0] deskew_done,
    output var  logic [1:0] initial_lane_sync_ok,
    output var  logic [1:0] config_checksum_ok,
    output var  logic [1:0] frame_sync_ok,
    output var  logic [1:0] code_group_sync_ok
);
    initial begin
        {disparity_err, invalid_code_err, stray_ctrl_err} = '0;
        {deskew_done, initial_lane_sync_ok, config_checksum_ok} = '0;
        {frame_sync_ok, code_group_sync_ok} = '0;
    end

    task automatic set_status(input int lane, input logic [4:0] b);
        @(negedge ref_clk);
        deskew_done[lane]          = b[4];
        initial_lane_sync_ok[lane] = b[3];
        config_checksum_ok[lane]   = b[2];
        frame_sync_ok[lane]        = b[1];
        code_group_sync_ok[lane]   = b[0];
    endtask : set_status

    // Events arrive on consecutive cycles, the hardest case for a counter.
    task automatic burst(input int lane, input int kind, input int n);
        repeat (n) begin
            @(negedge ref_clk);
            case (kind)
                0: disparity_err[lane] = 1'b1;
                1: invalid_code_err[lane] = 1'b1;
                default: stray_ctrl_err[lane] = 1'b1;
            endcase
        end
        @(negedge ref_clk);
        {disparity_err, invalid_code_err, stray_ctrl_err} = '0;
    endtask : burst
endmodule : lane_source_model
`default_nettype wire

// >>> verification/serial_lane_link_status_test.sv
`timescale 1ns/1ps
`default_nettype none
module serial_lane_link_status_test;
    import link_health_pkg::*;
    logic              ref_clk = 1'b0;
    logic              reset_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic              reg_rd_en = 1'b0;
    logic              reg_wr_en = 1'b0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic [DATA_W-1:0] reg_rdata;
    logic              reg_rd_valid;
    logic [7:0]        error_threshold = 8'h03;
    logic              clear_error_counts = 1'b0;
    logic              skip_alignment_sequence = 1'b0;
    logic [1:0]        d_err, i_err, s_err, dsk, ils, cks, fs, cgs;
    int                fail_count = 0;
    int                cmp_count = 0;
    int                cycles = 0;

    always #4 ref_clk = ~ref_clk;

    serial_lane_link_status dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_rd_en(reg_rd_en), .reg_wr_en(reg_wr_en),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rd_valid(reg_rd_valid), .error_threshold(error_threshold),
        .clear_error_counts(clear_error_counts),
        .skip_alignment_sequence(skip_alignment_sequence),
        .disparity_err(d_err), .invalid_code_err(i_err),
        .stray_ctrl_err(s_err), .deskew_done(dsk),
        .initial_lane_sync_ok(ils), .config_checksum_ok(cks),
        .frame_sync_ok(fs), .code_group_sync_ok(cgs));

    lane_source_model src (.ref_clk(ref_clk), .disparity_err(d_err),
        .invalid_code_err(i_err), .stray_ctrl_err(s_err),
        .deskew_done(dsk), .initial_lane_sync_ok(ils),
        .config_checksum_ok(cks), .frame_sync_ok(fs),
        .code_group_sync_ok(cgs));

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Valid is looked at in the one cycle it stands.
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        reg_addr  = a;
        reg_rd_en = 1'b1;
        @(negedge ref_clk);
        reg_rd_en = 1'b0;
        check({7'h00, reg_rd_valid}, 8'h01);
        check(reg_rdata, exp);
    endtask : rd

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge ref_clk);
        reg_wr_en = 1'b0;
    endtask : wr

    // Event to flag takes two cycles; one more keeps clear of the edge.
    task automatic settle();
        repeat (3) @(negedge ref_clk);
    endtask : settle

    task automatic close_out();
        $display("mismatches %0d comparisons %0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    // A correct run needs under 1000 cycles.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            close_out();
        end
    end

    initial begin
        repeat (5) @(negedge ref_clk);
        reset_n = 1'b1;
        rd(LANE2_HEALTH_OFS, HEALTH_RESET);
        rd(LANE3_HEALTH_OFS, HEALTH_RESET);
        rd(12'h4B4, UNMAPPED_RDATA);
        for (int i = 0; i < 5; i++) begin
            src.set_status(0, 5'(5'h01 << i));
            src.set_status(1, 5'(~(5'h01 << i)));
            settle();
            rd(LANE2_HEALTH_OFS, 8'(8'h01 << i));
            rd(LANE3_HEALTH_OFS, {3'h0, ~5'(5'h01 << i)});
        end
        skip_alignment_sequence = 1'b1;
        // Code group sync must still be reported with the sequence skipped.
        src.set_status(0, 5'h11);
        settle();
        rd(LANE2_HEALTH_OFS, 8'h11);
        rd(LANE3_HEALTH_OFS, 8'h0F);
        src.set_status(0, 5'h10);
        settle();
        rd(LANE2_HEALTH_OFS, 8'h10);
        wr(LANE2_HEALTH_OFS, 8'hFF);
        rd(LANE2_HEALTH_OFS, 8'h10);
        src.burst(0, 0, 2);
        settle();
        rd(LANE2_HEALTH_OFS, 8'h10);
        src.burst(0, 0, 1);
        settle();
        rd(LANE2_HEALTH_OFS, 8'h90);
        src.burst(1, 1, 3);
        settle();
        rd(LANE3_HEALTH_OFS, 8'h4F);
        src.burst(0, 2, 3);
        settle();
        rd(LANE2_HEALTH_OFS, 8'hB0);
        error_threshold = 8'h04;
        settle();
        rd(LANE2_HEALTH_OFS, 8'h10);
        clear_error_counts = 1'b1;
        error_threshold = 8'h01;
        settle();
        clear_error_counts = 1'b0;
        rd(LANE3_HEALTH_OFS, 8'h0F);
        // A wrapping counter would end at 4 and miss the top threshold.
        error_threshold = 8'hFF;
        src.burst(1, 0, 260);
        settle();
        rd(LANE3_HEALTH_OFS, 8'h8F);
        error_threshold = 8'h00;
        settle();
        rd(LANE2_HEALTH_OFS, 8'hF0);
        close_out();
    end
endmodule : serial_lane_link_status_test
`default_nettype wire
